// ### core/tx_flags_pkg.sv
/*
  constants, field layout and state codes shared by the transmitter's
  user-side framer, its fifo and its octet boundary chain.
  assumes a single lane clock and word-aligned register addresses.
*/
package tx_flags_pkg;
  localparam int OCTET_W          = 8;
  localparam int LOW_LANE_W       = 16;
  localparam int HIGH_LANE_W      = 32;
  localparam int DEF_LANES        = 2;
  localparam int FIFO_DEPTH       = 8;
  localparam int SYNC_STAGES      = 3;

  // register bus
  localparam int ADDR_W           = 4;
  localparam int DATA_W           = 32;
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_WORDS  = 4'h8;
  localparam logic [3:0] REG_BUILD  = 4'hc;

  // config fields
  localparam int CFG_ENABLE_BIT   = 0;
  localparam int CFG_F_LSB        = 8;
  localparam int CFG_F_W          = 8;
  localparam int CFG_K_LSB        = 16;
  localparam int CFG_K_W          = 5;
  localparam logic       CFG_ENABLE_RST = 1'b0;
  localparam logic [7:0] CFG_F_M1_RST   = 8'h02;
  localparam logic [4:0] CFG_K_M1_RST   = 5'h07;

  // status fields
  localparam int ST_DEMAND_BIT    = 0;
  localparam int ST_VALID_BIT     = 1;
  localparam int ST_RUN_BIT       = 2;
  localparam int ST_UNDERRUN_BIT  = 3;
  localparam int ST_LEVEL_LSB     = 8;
  localparam int ST_FO_LSB        = 16;
  localparam int ST_FK_LSB        = 24;

  // build fields
  localparam int BLD_HIGH_BIT     = 0;
  localparam int BLD_LANES_LSB    = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;
endpackage

// ### core/lane_fifo_if.sv
/*
  valid/ready carrier between the framer and its lane fifo.
  assumes both ends run on the lane clock.
*/
`timescale 1ns/1ps
interface lane_fifo_if #(parameter int WIDTH = 32, parameter int LVL_W = 4);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic [LVL_W-1:0] level;

  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data,
                output level);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data,
                input level);
endinterface

// ### core/lane_fifo.sv
/*
  lane word fifo: ring of DEPTH words plus a registered output stage.
  assumes DEPTH is a power of two; level counts ring words only.
*/
`timescale 1ns/1ps
module lane_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int LVL_W = 4
) (
  // clock and reset
  input wire logic    sys_clk,
  input wire logic    rst_n,
  // both sides
  lane_fifo_if.fifo   f
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd;
    logic [PW-1:0]               wr;
    logic [LVL_W-1:0]            cnt;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        push;
  logic        load;

  assign f.in_ready  = (s_reg.cnt != LVL_W'(DEPTH));
  assign f.out_valid = s_reg.out_valid;
  assign f.out_data  = s_reg.out_data;
  assign f.level     = s_reg.cnt;

  always_comb begin
    s_next = s_reg;
    push   = f.in_valid && f.in_ready;
    load   = !s_reg.out_valid || f.out_ready;
    if (load) begin
      s_next.out_valid = 1'b0;
      if (s_reg.cnt != '0) begin
        s_next.out_valid = 1'b1;
        s_next.out_data  = s_reg.mem[s_reg.rd];
        s_next.rd        = s_reg.rd + 1'b1;
      end
    end
    if (push) begin
      s_next.mem[s_reg.wr] = f.in_data;
      s_next.wr            = s_reg.wr + 1'b1;
    end
    s_next.cnt = s_reg.cnt + LVL_W'(push)
               - LVL_W'(load && (s_reg.cnt != '0));
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // lane_fifo

// ### core/boundary_octet.sv
/*
  one octet of the boundary chain: marks frame end, multiframe start
  and end for the octet at (fo, fk), and yields the next octet's place.
  purely combinational; assumes fo <= f_m1 and fk <= k_m1.
*/
`timescale 1ns/1ps
module boundary_octet #(
  parameter int FW = 8,
  parameter int KW = 5
) (
  // place of this octet and frame geometry
  input  wire logic [FW-1:0] fo,
  input  wire logic [KW-1:0] fk,
  input  wire logic [FW-1:0] f_m1,
  input  wire logic [KW-1:0] k_m1,
  // marks
  output logic               frame_end,
  output logic               mf_start,
  output logic               mf_end,
  // place of the following octet
  output logic [FW-1:0]      fo_nx,
  output logic [KW-1:0]      fk_nx
);
  always_comb begin
    frame_end = (fo == f_m1);
    mf_start  = (fo == '0) && (fk == '0);
    mf_end    = frame_end && (fk == k_m1);
    fo_nx     = frame_end ? '0 : fo + 1'b1;
    fk_nx     = fk;
    if (frame_end) begin
      fk_nx = (fk == k_m1) ? '0 : fk + 1'b1;
    end
  end
endmodule // boundary_octet

// ### core/tx_frame_boundary_flags.sv
/*
  user side of the link transmitter: takes aligned lane words, keeps
  the frame and multiframe octet count, and shows per byte position the
  frame end and multiframe start/end of the next word it will take.
  assumes user logic sits on sys_clk and puts a word on usr_data_in in
  every cycle following a high usr_ready.
*/
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module tx_frame_boundary_flags
  import tx_flags_pkg::*;
#(
  parameter bit HIGH_RATE = 1'b0,
  parameter int LANES     = tx_flags_pkg::DEF_LANES,
  parameter int DEPTH     = tx_flags_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 half_rate_clock,
  // user data
  input  wire logic [LANES*(HIGH_RATE ? tx_flags_pkg::HIGH_LANE_W
                     : tx_flags_pkg::LOW_LANE_W)-1:0] usr_data_in,
  output logic                      usr_ready,
  // boundary flags for the next word
  output logic [(HIGH_RATE ? 2 : 1)-1:0] multiframe_end_low_flag,
  output logic [(HIGH_RATE ? 2 : 1)-1:0] multiframe_end_high_flag,
  output logic [(HIGH_RATE ? 2 : 1)-1:0] multiframe_start_low_flag,
  output logic [(HIGH_RATE ? 2 : 1)-1:0] multiframe_start_high_flag,
  output logic [(HIGH_RATE ? 2 : 1)-1:0] frame_end_low_flag,
  output logic [(HIGH_RATE ? 2 : 1)-1:0] frame_end_high_flag,
  // lane words towards the scrambler
  output logic [LANES*(HIGH_RATE ? tx_flags_pkg::HIGH_LANE_W
                : tx_flags_pkg::LOW_LANE_W)-1:0] lane_data,
  output logic                      lane_valid,
  input  wire logic                 lane_ready,
  // register port
  input  wire logic [tx_flags_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [tx_flags_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic [tx_flags_pkg::DATA_W-1:0] reg_rdata
);
  import tx_flags_pkg::*;

  localparam int LANE_W = HIGH_RATE ? HIGH_LANE_W : LOW_LANE_W;
  localparam int W      = HIGH_RATE ? 2 : 1;
  localparam int OCTS   = 2 * W;
  localparam int WORD_W = LANES * LANE_W;
  localparam int LVL_W  = $clog2(DEPTH) + 1;
  localparam int FW     = CFG_F_W;
  localparam int KW     = CFG_K_W;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] hclk_sync;
    run_state_t             state;
    logic                   enable;
    logic [FW-1:0]          f_m1;
    logic [KW-1:0]          k_m1;
    logic                   demand;
    logic                   take;
    logic [FW-1:0]          fo;
    logic [KW-1:0]          fk;
    logic [W-1:0]           mfe_l;
    logic [W-1:0]           mfe_h;
    logic [W-1:0]           mfs_l;
    logic [W-1:0]           mfs_h;
    logic [W-1:0]           fe_l;
    logic [W-1:0]           fe_h;
    logic                   underrun;
    logic                   seen_data;
    logic [DATA_W-1:0]      words;
    logic [DATA_W-1:0]      rdata;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;

  lane_fifo_if #(.WIDTH(WORD_W), .LVL_W(LVL_W)) lf ();

  // two octet chains: [0] steps from the held place, [1] marks the
  // place that will be current next cycle
  logic [FW-1:0] ch_fo [2][OCTS+1];
  logic [KW-1:0] ch_fk [2][OCTS+1];
  logic          ch_fe [2][OCTS];
  logic          ch_ms [2][OCTS];
  logic          ch_me [2][OCTS];
  logic [FW-1:0] next_fo;
  logic [KW-1:0] next_fk;

  assign ch_fo[0][0] = st_reg.fo;
  assign ch_fk[0][0] = st_reg.fk;
  assign ch_fo[1][0] = next_fo;
  assign ch_fk[1][0] = next_fk;

  for (genvar c = 0; c < 2; c++) begin : g_chain
    for (genvar j = 0; j < OCTS; j++) begin : g_oct
      boundary_octet #(.FW(FW), .KW(KW)) u_oct (
        .fo        (ch_fo[c][j]),
        .fk        (ch_fk[c][j]),
        .f_m1      (st_reg.f_m1),
        .k_m1      (st_reg.k_m1),
        .frame_end (ch_fe[c][j]),
        .mf_start  (ch_ms[c][j]),
        .mf_end    (ch_me[c][j]),
        .fo_nx     (ch_fo[c][j+1]),
        .fk_nx     (ch_fk[c][j+1])
      );
    end
  end

  lane_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .f       (lf.fifo)
  );

  // the word is written the cycle it arrives; no hold-off from in_ready
  // is possible there, so demand is only raised with room reserved
  assign lf.in_valid  = st_reg.take;
  assign lf.in_data   = usr_data_in;
  assign lf.out_ready = lane_ready;

  assign usr_ready                  = st_reg.demand;
  assign multiframe_end_low_flag    = st_reg.mfe_l;
  assign multiframe_end_high_flag   = st_reg.mfe_h;
  assign multiframe_start_low_flag  = st_reg.mfs_l;
  assign multiframe_start_high_flag = st_reg.mfs_h;
  assign frame_end_low_flag         = st_reg.fe_l;
  assign frame_end_high_flag        = st_reg.fe_h;
  assign lane_data                  = lf.out_data;
  assign lane_valid                 = lf.out_valid;
  assign reg_rdata                  = st_reg.rdata;

  always_comb begin
    logic             slot;
    logic             room;
    logic             cfg_wr;
    logic [LVL_W+1:0] used;
    room    = 1'b0;
    used    = '0;
    st_next = st_reg;
    slot    = 1'b1;
    cfg_wr  = reg_write && (reg_addr == REG_CONFIG);

    // first stage feeds only the second; edge looks at later stages
    st_next.hclk_sync = {st_reg.hclk_sync[SYNC_STAGES-2:0],
                         half_rate_clock};
    if (HIGH_RATE) begin
      slot = st_reg.hclk_sync[1] && !st_reg.hclk_sync[2];
    end

    // place of the word taken next: advance past the word now due
    next_fo = st_reg.demand ? ch_fo[0][OCTS] : st_reg.fo;
    next_fk = st_reg.demand ? ch_fk[0][OCTS] : st_reg.fk;

    // ring words plus the two writes already promised
    used = (LVL_W+2)'(lf.level) + (LVL_W+2)'(st_reg.take)
         + (LVL_W+2)'(st_reg.demand);
    room = (used < (LVL_W+2)'(DEPTH)) && lf.in_ready;

    st_next.take = st_reg.demand;
    if (st_reg.take) begin
      st_next.words = st_reg.words + 32'h1;
    end

    unique case (st_reg.state)
      ST_IDLE: begin
        st_next.demand = 1'b0;
        st_next.fo     = '0;
        st_next.fk     = '0;
        if (st_reg.enable && !cfg_wr) begin
          st_next.state = ST_RUN;
        end
      end
      ST_RUN: begin
        st_next.fo     = next_fo;
        st_next.fk     = next_fk;
        st_next.demand = room && slot;
        // geometry change restarts counting from a multiframe start
        if (!st_reg.enable || cfg_wr) begin
          st_next.state  = ST_IDLE;
          st_next.demand = 1'b0;
        end
      end
    endcase

    // flags always go with demand: they name the word of next cycle
    st_next.mfe_l = '0;
    st_next.mfe_h = '0;
    st_next.mfs_l = '0;
    st_next.mfs_h = '0;
    st_next.fe_l  = '0;
    st_next.fe_h  = '0;
    if (st_next.demand) begin
      for (int b = 0; b < W; b++) begin
        st_next.mfe_l[b] = ch_me[1][2*b];
        st_next.mfe_h[b] = ch_me[1][2*b+1];
        st_next.mfs_l[b] = ch_ms[1][2*b];
        st_next.mfs_h[b] = ch_ms[1][2*b+1];
        st_next.fe_l[b]  = ch_fe[1][2*b];
        st_next.fe_h[b]  = ch_fe[1][2*b+1];
      end
    end

    // serializer asking while nothing is staged after data flowed
    if (lf.out_valid) begin
      st_next.seen_data = 1'b1;
    end
    if (reg_write && (reg_addr == REG_STATUS)
        && reg_wdata[ST_UNDERRUN_BIT]) begin
      st_next.underrun = 1'b0;
    end
    if (st_reg.seen_data && lane_ready && !lf.out_valid) begin
      st_next.underrun = 1'b1;
    end

    if (cfg_wr) begin
      st_next.enable = reg_wdata[CFG_ENABLE_BIT];
      st_next.f_m1   = reg_wdata[CFG_F_LSB +: CFG_F_W];
      st_next.k_m1   = reg_wdata[CFG_K_LSB +: CFG_K_W];
    end

    // read data stands only in the cycle after the strobe
    st_next.rdata = '0;
    if (reg_read) begin
      unique case (reg_addr)
        REG_CONFIG: begin
          st_next.rdata[CFG_ENABLE_BIT]       = st_reg.enable;
          st_next.rdata[CFG_F_LSB +: CFG_F_W] = st_reg.f_m1;
          st_next.rdata[CFG_K_LSB +: CFG_K_W] = st_reg.k_m1;
        end
        REG_STATUS: begin
          st_next.rdata[ST_DEMAND_BIT]          = st_reg.demand;
          st_next.rdata[ST_VALID_BIT]           = lf.out_valid;
          st_next.rdata[ST_RUN_BIT]             = st_reg.state == ST_RUN;
          st_next.rdata[ST_UNDERRUN_BIT]        = st_reg.underrun;
          st_next.rdata[ST_LEVEL_LSB +: LVL_W]  = lf.level;
          st_next.rdata[ST_FO_LSB +: FW]        = st_reg.fo;
          st_next.rdata[ST_FK_LSB +: KW]        = st_reg.fk;
        end
        REG_WORDS: begin
          st_next.rdata = st_reg.words;
        end
        REG_BUILD: begin
          st_next.rdata[BLD_HIGH_BIT]      = HIGH_RATE;
          st_next.rdata[BLD_LANES_LSB +: 8] = 8'(LANES);
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.state     <= ST_IDLE;
      st_reg.enable    <= CFG_ENABLE_RST;
      st_reg.f_m1      <= CFG_F_M1_RST;
      st_reg.k_m1      <= CFG_K_M1_RST;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // tx_frame_boundary_flags

// ### test/tx_flags_properties.sv
/* port checker for the boundary flag block.
   assumes sys_clk rising edge and low active sync reset rst_n. */
`timescale 1ns/1ps
module tx_flags_chk
  import tx_flags_pkg::*;
#(
  parameter bit HIGH_RATE = 1'b0,
  parameter int LANES     = 2
) (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  // user side
  input wire logic                 usr_ready,
  input wire logic [(HIGH_RATE ? 2 : 1)-1:0] multiframe_end_low_flag,
  input wire logic [(HIGH_RATE ? 2 : 1)-1:0] multiframe_end_high_flag,
  input wire logic [(HIGH_RATE ? 2 : 1)-1:0] multiframe_start_low_flag,
  input wire logic [(HIGH_RATE ? 2 : 1)-1:0] multiframe_start_high_flag,
  input wire logic [(HIGH_RATE ? 2 : 1)-1:0] frame_end_low_flag,
  input wire logic [(HIGH_RATE ? 2 : 1)-1:0] frame_end_high_flag,
  // lane side
  input wire logic [LANES*(HIGH_RATE ? HIGH_LANE_W
                    : LOW_LANE_W)-1:0] lane_data,
  input wire logic                 lane_valid,
  input wire logic                 lane_ready
);
  import tx_flags_pkg::*;
  wire any_flag = |{multiframe_end_low_flag, multiframe_end_high_flag,
    multiframe_start_low_flag, multiframe_start_high_flag,
    frame_end_low_flag, frame_end_high_flag};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  flags_idle_a: assert property (!usr_ready |-> !any_flag)
    else $error("flag shown without ready");
  reset_quiet_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    !rst_n |=> !usr_ready && !any_flag && !lane_valid)
    else $error("outputs active after reset cycle");
  mf_low_pair_a: assert property (multiframe_end_low_flag[0]
    |-> multiframe_start_high_flag[0]) else $error("no start after low end");
  mf_high_pair_a: assert property (multiframe_end_high_flag[0]
    ##1 usr_ready |-> multiframe_start_low_flag[0])
    else $error("no start after high end");
  mfe_low_frame_a: assert property (multiframe_end_low_flag[0]
    |-> frame_end_low_flag[0]) else $error("mf end low without frame end");
  mfe_high_frame_a: assert property (multiframe_end_high_flag[0]
    |-> frame_end_high_flag[0]) else $error("mf end high without frame end");
  mfs_low_cause_a: assert property (multiframe_start_low_flag[0]
    && $past(usr_ready) |-> $past(multiframe_end_high_flag[0]))
    else $error("start low without prior end");
  mfs_high_cause_a: assert property (multiframe_start_high_flag[0]
    |-> multiframe_end_low_flag[0]) else $error("start high without end");
  lane_hold_a: assert property (lane_valid && !lane_ready
    |=> lane_valid && $stable(lane_data)) else $error("lane word dropped");

  cover property (multiframe_start_low_flag[0]);
  cover property (usr_ready ##1 !usr_ready && lane_valid && !lane_ready);
  cover property (frame_end_low_flag[0] && frame_end_high_flag[0]);
endmodule // tx_flags_chk

bind tx_frame_boundary_flags tx_flags_chk #(.HIGH_RATE(HIGH_RATE),
  .LANES(LANES)) chk (.sys_clk, .rst_n, .usr_ready,
  .multiframe_end_low_flag, .multiframe_end_high_flag,
  .multiframe_start_low_flag, .multiframe_start_high_flag,
  .frame_end_low_flag, .frame_end_high_flag,
  .lane_data, .lane_valid, .lane_ready);

// ### test/user_feed.sv
/* user logic model: puts one word on the data input after each ready.
   assumes it shares sys_clk with the transmitter. */
`timescale 1ns/1ps
module user_feed #(
  parameter int LW = 32
) (
  // clock and reset
  input wire logic           sys_clk,
  input wire logic           rst_n,
  // handshake
  input wire logic           usr_ready,
  output logic [LW-1:0]      usr_data_in
);
  initial usr_data_in = '0;
  // no word owed: churn the line so a stale word never looks valid
  always @(posedge sys_clk)
    if (rst_n && usr_ready) usr_data_in <= LW'($urandom);
    else usr_data_in <= ~usr_data_in;
endmodule // user_feed

// ### test/testbench.sv
/* self-checking bench: random configs, fifo stall, mid-run reset.
   assumes the low-rate build with two lanes. */
`timescale 1ns/1ps
module testbench;
  import tx_flags_pkg::*;
  localparam int LW = DEF_LANES * LOW_LANE_W;
  logic              sys_clk = 0, rst_n = 0, lane_ready = 0, hold = 0;
  logic              reg_write = 0, reg_read = 0, took = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, d;
  wire  [DATA_W-1:0] reg_rdata;
  wire  [LW-1:0]     usr_data_in, lane_data;
  wire               usr_ready, lane_valid;
  wire  [0:0]        multiframe_end_low_flag, multiframe_end_high_flag;
  wire  [0:0]        multiframe_start_low_flag, multiframe_start_high_flag;
  wire  [0:0]        frame_end_low_flag, frame_end_high_flag;
  int miscompares = 0, samples_checked = 0, pos = 0, fc = 3, kc = 8;
  int n_took = 0;
  logic [LW-1:0] q[$];

  always #5 sys_clk = ~sys_clk;

  tx_frame_boundary_flags uut (.sys_clk, .rst_n, .half_rate_clock(1'b0),
    .usr_data_in, .usr_ready, .multiframe_end_low_flag,
    .multiframe_end_high_flag, .multiframe_start_low_flag,
    .multiframe_start_high_flag, .frame_end_low_flag, .frame_end_high_flag,
    .lane_data, .lane_valid, .lane_ready, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata);
  user_feed #(.LW(LW)) feed (.sys_clk, .rst_n, .usr_ready, .usr_data_in);

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask

  // bits: fe low/high, mfs low/high, mfe low/high for octets p, p+1
  function automatic logic [31:0] exp_flags(int p, int f, int k);
    logic [31:0] r;
    int o;
    r = '0;
    for (int j = 0; j < 2; j++) begin
      o = (p + j) % (f * k);
      r[j] = (o % f) == f - 1;
      r[2+j] = o == 0;
      r[4+j] = o == f * k - 1;
    end
    return r;
  endfunction

  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) lane_ready <= !hold && ($urandom % 3 != 0);

  // flag and lane word scoreboard on pre-edge values
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      q.delete();
      n_took = 0;
      pos = 0; fc = 3; kc = 8;
    end else begin
      if (usr_ready) begin
        cmp({26'h0, multiframe_end_high_flag, multiframe_end_low_flag,
             multiframe_start_high_flag, multiframe_start_low_flag,
             frame_end_high_flag, frame_end_low_flag},
            exp_flags(pos, fc, kc), "flags");
        pos = (pos + 2) % (fc * kc);
      end
      if (reg_write && reg_addr == REG_CONFIG) begin
        pos = 0;
        fc = int'(reg_wdata[15:8]) + 1;
        kc = int'(reg_wdata[20:16]) + 1;
      end
      if (lane_valid && lane_ready) cmp(lane_data, q.pop_front(), "word");
      if (took) begin
        q.push_back(usr_data_in);
        n_took++;
      end
    end
    took = rst_n && usr_ready;
  end

  initial begin
    void'($urandom(32'h1e009777));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(REG_CONFIG, d); cmp(d, 32'h0007_0200, "config reset");
    rd(REG_BUILD, d); cmp(d, 32'h0000_0200, "build");
    wr(REG_BUILD, '1);
    rd(REG_BUILD, d); cmp(d, 32'h0000_0200, "build ro");
    rd(4'h2, d); cmp(d, 32'h0, "unmapped");
    for (int i = 0; i < 6; i++) begin
      wr(REG_CONFIG, {11'h0, i == 0 ? 5'h07 : i == 1 ? 5'h00 : 5'($urandom),
         i == 0 ? 8'h02 : i == 1 ? 8'h00 : 8'($urandom % 8), 8'h01});
      repeat (60) @(posedge sys_clk);
    end
    // stall the lane side until the fifo refuses words
    hold <= 1'b1;
    repeat (30) @(posedge sys_clk);
    cmp({31'h0, usr_ready}, 32'h0, "ready when full");
    rd(REG_STATUS, d); cmp(d & 32'h0000_0f07, 32'h0000_0806, "full");
    hold <= 1'b0;
    repeat (40) @(posedge sys_clk);
    wr(REG_CONFIG, 32'h0);
    repeat (30) @(posedge sys_clk);
    cmp({31'h0, lane_valid}, 32'h0, "drained");
    rd(REG_WORDS, d); cmp(d, 32'(n_took), "words");
    wr(REG_CONFIG, 32'h0007_0201);
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    cmp({31'h0, usr_ready}, 32'h0, "ready in reset");
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(REG_CONFIG, d); cmp(d, 32'h0007_0200, "config rerun");
    wr(REG_CONFIG, 32'h0007_0201);
    repeat (40) @(posedge sys_clk);
    give_verdict();
  end

  // whole run is near 550 cycles
  initial begin
    #50us;
    miscompares++;
    give_verdict();
  end
endmodule // testbench
